// >>> hdl/fspr_defs.svh
// constants of the flash self-program readout block
// assumes a 50 MHz aclk; included by the package and both ends
`ifndef FSPR_DEFS_SVH
`define FSPR_DEFS_SVH
`define FSPR_CLK_PER_NS 20
`define FSPR_OP_MIN_NS  3700000
`define FSPR_OP_MAX_NS  4500000
`define FSPR_OP_MIN_CYC ((`FSPR_OP_MIN_NS+`FSPR_CLK_PER_NS-1)/`FSPR_CLK_PER_NS)
`define FSPR_OP_MAX_CYC (`FSPR_OP_MAX_NS/`FSPR_CLK_PER_NS)
`define FSPR_WIN_SPM    3'h4
`define FSPR_WIN_LPM    3'h3
`define FSPR_B_EN       0
`define FSPR_B_ERS      1
`define FSPR_B_WRT      2
`define FSPR_B_LCK      3
`define FSPR_B_REEN     4
`define FSPR_B_SIG      5
`define FSPR_B_BUSY     6
`define FSPR_CMD_FILL   6'h01
`define FSPR_CMD_ERASE  6'h03
`define FSPR_CMD_WRITE  6'h05
`define FSPR_CMD_LOCK   6'h09
`define FSPR_CMD_REEN   6'h11
`define FSPR_CMD_SIG    6'h21
`define FSPR_CSR_RST    8'h00
`define FSPR_Z_FLB      2'h0
`define FSPR_Z_LOCK     2'h1
`define FSPR_Z_EFB      2'h2
`define FSPR_Z_FHB      2'h3
`define FSPR_EFB_UNUSED 5'h1F
`define FSPR_BLOCKED_RD 8'hFF
`define FSPR_BOOT_SIZE_FUSE_FIELD_LSB 1
`define FSPR_BOOT_256   14'h3F00
`define FSPR_BOOT_512   14'h3E00
`define FSPR_BOOT_1K    14'h3C00
`define FSPR_BOOT_2K    14'h3800
`define FSPR_RWW_PAGES  8'hE0
`define FSPR_A_CTRL     4'h0
`define FSPR_A_ZPTR     4'h4
`define FSPR_A_DATA     4'h8
`define FSPR_A_STAT     4'hC
`define FSPR_RESP_OK    2'h0
`define FSPR_RESP_ERR   2'h2
`endif

// >>> hdl/fspr_dev.sv
// flash control end: store control register, readout, op timing
// assumes a cpu core end on fspr_if and a flash array on user side
`timescale 1ns/1ps
`include "fspr_defs.svh"
module fspr_dev #(
    parameter int unsigned OP_CYCLES = `FSPR_OP_MIN_CYC,
    // arbitrary signature contents
    parameter logic [63:0] SIG_ROW   = 64'h5a5a_0102_0304_a5a5
) (
    // clock and resets
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             por_n,
    // cpu core link
    fspr_if.dev                   bus,
    // fuse and lock values, programmed bit = 0
    input  wire fspr_pkg::fspr_byte_t fuse_low,
    input  wire fspr_pkg::fspr_byte_t fuse_high,
    input  wire logic [2:0]       fuse_ext,
    input  wire fspr_pkg::fspr_byte_t lock_bits,
    // flash array
    input  wire fspr_pkg::fspr_byte_t flash_rdata,
    output logic                  buf_wr,
    output logic [5:0]            buf_word,
    output fspr_pkg::fspr_word_t  buf_data,
    output logic                  buf_clear,
    output logic                  page_erase,
    output logic                  page_write,
    output logic [7:0]            page_sel,
    output logic                  lock_wr,
    output fspr_pkg::fspr_byte_t  lock_data,
    output logic                  op_busy,
    // boot section start from the fuses
    output fspr_pkg::fspr_pc_t    boot_start
);
    import fspr_pkg::*;

    typedef struct packed {
        logic [5:0]  cmd;
        logic [2:0]  cnt;
        logic        busy;
        logic        op;
        logic [17:0] opc;
        logic        opw;
        logic        halt;
        logic [7:0]  rd;
        logic [7:0]  ld;
        logic        lv;
        logic        bw;
        logic [5:0]  bwd;
        logic [15:0] bdat;
        logic        bclr;
        logic        ers;
        logic        wrt;
        logic [7:0]  pg;
        logic        lw;
        logic [7:0]  ldat;
        fspr_pc_t    boot;
    } fspr_dev_t;

    localparam fspr_dev_t RST = '0;
    localparam logic [17:0] OP_LAST = 18'(OP_CYCLES - 1);

    fspr_dev_t st_ff;
    fspr_dev_t nxt_st;

    function automatic logic legal(input logic [7:0] w);
        return w[5:0] == `FSPR_CMD_FILL  || w[5:0] == `FSPR_CMD_ERASE ||
               w[5:0] == `FSPR_CMD_WRITE || w[5:0] == `FSPR_CMD_LOCK  ||
               w[5:0] == `FSPR_CMD_REEN  || w[5:0] == `FSPR_CMD_SIG;
    endfunction

    // bytes go out as stored: programmed reads 0
    function automatic fspr_byte_t cfg_byte(input logic [1:0] a);
        fspr_byte_t b;
        b = fuse_low;
        unique case (a)
            `FSPR_Z_FLB:  b = fuse_low;
            `FSPR_Z_LOCK: b = lock_bits;
            `FSPR_Z_EFB:  b = {`FSPR_EFB_UNUSED, fuse_ext};
            `FSPR_Z_FHB:  b = fuse_high;
        endcase
        return b;
    endfunction

    // pages below 224 belong to the rww region
    function automatic logic in_rww(input logic [7:0] page);
        return page < `FSPR_RWW_PAGES;
    endfunction

    function automatic fspr_pc_t boot_of(input logic [1:0] sz);
        fspr_pc_t a;
        a = `FSPR_BOOT_256;
        unique case (sz)
            2'b11: a = `FSPR_BOOT_256;
            2'b10: a = `FSPR_BOOT_512;
            2'b01: a = `FSPR_BOOT_1K;
            2'b00: a = `FSPR_BOOT_2K;
        endcase
        return a;
    endfunction

    // reset clears all but a running flash operation, the page select, the rww busy flag, the buffer clear pulse and the boot start
    function automatic fspr_dev_t keep_op(input fspr_dev_t n);
        fspr_dev_t k;
        k = RST;
        k.op = n.op;
        k.opc = n.opc;
        k.opw = n.opw;
        k.halt = n.halt;
        k.busy = n.busy;
        k.cmd = n.op ? n.cmd : 6'h00;
        k.pg = n.pg;
        k.bclr = n.bclr;
        k.boot = n.boot;
        k.rd = {1'b0, k.busy, k.cmd};
        return k;
    endfunction

    always_comb begin
        logic pend;
        logic win_spm;
        logic win_lpm;
        pend = 1'b0;
        win_spm = 1'b0;
        win_lpm = 1'b0;
        nxt_st = st_ff;
        nxt_st.lv = 1'b0;
        nxt_st.bw = 1'b0;
        nxt_st.bclr = 1'b0;
        nxt_st.ers = 1'b0;
        nxt_st.wrt = 1'b0;
        nxt_st.lw = 1'b0;
        nxt_st.boot = boot_of(fuse_high[`FSPR_BOOT_SIZE_FUSE_FIELD_LSB +: 2]);
        pend = st_ff.cmd[`FSPR_B_EN] && !st_ff.op;
        win_spm = pend && st_ff.cnt < `FSPR_WIN_SPM;
        win_lpm = pend && st_ff.cnt < `FSPR_WIN_LPM;
        if (pend) begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
        end
        // operation timer; op time taken at the minimum
        if (st_ff.op) begin
            if (st_ff.opc == 18'h0_0000) begin
                nxt_st.op = 1'b0;
                nxt_st.cmd = 6'h00;
                nxt_st.halt = 1'b0;
                nxt_st.bclr = st_ff.opw;
            end else begin
                nxt_st.opc = st_ff.opc - 18'h0_0001;
            end
        end
        // unused window drops the command
        if (pend && st_ff.cnt == `FSPR_WIN_SPM - 3'h1 && !bus.spm) begin
            nxt_st.cmd = 6'h00;
        end
        if (pend && st_ff.cmd[`FSPR_B_SIG] &&
            st_ff.cnt == `FSPR_WIN_LPM - 3'h1 && !bus.lpm) begin
            nxt_st.cmd = 6'h00;
        end
        // a store while in signature mode does nothing
        if (win_spm && bus.spm && !st_ff.cmd[`FSPR_B_SIG]) begin
            nxt_st.cmd = 6'h00;
            unique case (st_ff.cmd)
                `FSPR_CMD_FILL: begin
                    nxt_st.bw = 1'b1;
                    nxt_st.bwd = bus.z[6:1];
                    nxt_st.bdat = bus.r;
                    nxt_st.busy = 1'b0;
                end
                `FSPR_CMD_ERASE, `FSPR_CMD_WRITE: begin
                    nxt_st.cmd = st_ff.cmd;
                    nxt_st.op = 1'b1;
                    nxt_st.opc = OP_LAST;
                    nxt_st.opw = st_ff.cmd[`FSPR_B_WRT];
                    nxt_st.ers = !st_ff.cmd[`FSPR_B_WRT];
                    nxt_st.wrt = st_ff.cmd[`FSPR_B_WRT];
                    nxt_st.pg = bus.z[14:7];
                    if (in_rww(bus.z[14:7])) begin
                        nxt_st.busy = 1'b1;
                    end else begin
                        nxt_st.halt = 1'b1;
                    end
                end
                `FSPR_CMD_LOCK: begin
                    nxt_st.cmd = st_ff.cmd;
                    nxt_st.op = 1'b1;
                    nxt_st.opc = OP_LAST;
                    nxt_st.opw = 1'b0;
                    nxt_st.lw = 1'b1;
                    nxt_st.ldat = bus.r[7:0];
                end
                `FSPR_CMD_REEN: begin
                    nxt_st.busy = 1'b0;
                    nxt_st.bclr = 1'b1;
                end
                default: ;
            endcase
        end
        if (bus.lpm) begin
            nxt_st.lv = 1'b1;
            if (win_lpm && st_ff.cmd[`FSPR_B_SIG]) begin
                nxt_st.ld = SIG_ROW[{bus.z[2:0], 3'h0} +: 8];
                nxt_st.cmd = 6'h00;
            end else if (win_lpm && st_ff.cmd[`FSPR_B_LCK]) begin
                nxt_st.ld = cfg_byte(bus.z[1:0]);
                nxt_st.cmd = 6'h00;
            end else if (st_ff.busy && in_rww(bus.z[14:7])) begin
                nxt_st.ld = `FSPR_BLOCKED_RD;
            end else begin
                nxt_st.ld = flash_rdata;
            end
        end
        // eeprom busy or a command in hand blocks the write
        if (bus.csr_wr && !bus.ee_busy && !st_ff.cmd[`FSPR_B_EN] &&
            legal(bus.csr_wdata)) begin
            nxt_st.cmd = bus.csr_wdata[5:0];
            nxt_st.cnt = 3'h0;
        end
        nxt_st.rd = {1'b0, nxt_st.busy, nxt_st.cmd};
    end

    always_ff @(posedge aclk) begin
        if (!por_n) begin
            st_ff <= RST;
        end else if (!aresetn) begin
            st_ff <= keep_op(nxt_st);
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.csr_rdata = st_ff.rd;
    assign bus.lpm_data = st_ff.ld;
    assign bus.lpm_valid = st_ff.lv;
    assign bus.rww_blocked = st_ff.busy;
    assign bus.cpu_halt = st_ff.halt;
    assign buf_wr = st_ff.bw;
    assign buf_word = st_ff.bwd;
    assign buf_data = st_ff.bdat;
    assign buf_clear = st_ff.bclr;
    assign page_erase = st_ff.ers;
    assign page_write = st_ff.wrt;
    assign page_sel = st_ff.pg;
    assign lock_wr = st_ff.lw;
    assign lock_data = st_ff.ldat;
    assign op_busy = st_ff.op;
    assign boot_start = st_ff.boot;
endmodule

// >>> hdl/fspr_host.sv
// cpu core end: runs timed store sequences ordered over axi4-lite
// assumes fspr_dev on the other side of fspr_if, same aclk
`timescale 1ns/1ps
`include "fspr_defs.svh"
module fspr_host (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite slave
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [3:0]   s_axi_awaddr,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    output logic [1:0]        s_axi_bresp,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    input  wire logic [3:0]   s_axi_araddr,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    // eeprom state and interrupt mask
    input  wire logic         ee_busy_in,
    output logic              irq_mask,
    // flash control link
    fspr_if.host              bus
);
    import fspr_pkg::*;

    typedef struct packed {
        fspr_hst_t   st;
        logic        dly;
        logic [7:0]  cmd;
        fspr_kind_t  kind;
        fspr_word_t  z;
        fspr_word_t  r;
        fspr_byte_t  lb;
        logic        cw;
        logic        spm;
        logic        lpm;
        logic        mask;
        logic        ee;
        logic        awr;
        logic        wr;
        logic        awg;
        logic        wg;
        logic [3:0]  awa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bv;
        logic [1:0]  br;
        logic        arr;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
    } fspr_host_t;

    localparam fspr_host_t RST = '{st: H_IDLE, kind: K_SPM,
        awr: 1'b1, wr: 1'b1, arr: 1'b1, default: '0};

    fspr_host_t st_ff;
    fspr_host_t nxt_st;

    function automatic fspr_word_t merge(input fspr_word_t o,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        fspr_word_t m;
        m = o;
        if (s[0]) m[7:0] = d[7:0];
        if (s[1]) m[15:8] = d[15:8];
        return m;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ee = ee_busy_in;
        // axi write: address and data in either order
        if (s_axi_awvalid && st_ff.awr) begin
            nxt_st.awr = 1'b0;
            nxt_st.awg = 1'b1;
            nxt_st.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wr) begin
            nxt_st.wr = 1'b0;
            nxt_st.wg = 1'b1;
            nxt_st.wd = s_axi_wdata;
            nxt_st.ws = s_axi_wstrb;
        end
        if (st_ff.bv && s_axi_bready) begin
            nxt_st.bv = 1'b0;
            nxt_st.awr = 1'b1;
            nxt_st.wr = 1'b1;
        end
        if (st_ff.arr && s_axi_arvalid) begin
            nxt_st.arr = 1'b0;
            nxt_st.rv = 1'b1;
            nxt_st.rr = `FSPR_RESP_OK;
            unique case (s_axi_araddr)
                `FSPR_A_CTRL: nxt_st.rd = {22'h0, st_ff.kind, st_ff.cmd};
                `FSPR_A_ZPTR: nxt_st.rd = {16'h0, st_ff.z};
                `FSPR_A_DATA: nxt_st.rd = {16'h0, st_ff.r};
                `FSPR_A_STAT: nxt_st.rd = {15'h0, st_ff.st != H_IDLE,
                                           st_ff.lb, bus.csr_rdata};
                default: begin
                    nxt_st.rd = 32'h0000_0000;
                    nxt_st.rr = `FSPR_RESP_ERR;
                end
            endcase
        end
        if (st_ff.rv && s_axi_rready) begin
            nxt_st.rv = 1'b0;
            nxt_st.arr = 1'b1;
        end
        // sequencer
        nxt_st.cw = 1'b0;
        nxt_st.spm = 1'b0;
        nxt_st.lpm = 1'b0;
        unique case (st_ff.st)
            H_IDLE: nxt_st.mask = 1'b0;
            H_POLL: begin
                nxt_st.mask = 1'b1;
                if (!bus.csr_rdata[`FSPR_B_EN] && !st_ff.ee) begin
                    nxt_st.cw = 1'b1;
                    nxt_st.st = H_EXEC;
                end
            end
            H_EXEC: begin
                // store issued one cycle after the write
                nxt_st.spm = st_ff.kind == K_SPM || st_ff.kind == K_RESUME;
                nxt_st.lpm = st_ff.kind == K_LPM;
                nxt_st.dly = 1'b0;
                if (st_ff.kind == K_LPM) begin
                    nxt_st.st = H_RDW;
                end else if (st_ff.kind == K_CSR) begin
                    nxt_st.st = H_IDLE;
                    nxt_st.mask = 1'b0;
                end else begin
                    nxt_st.st = H_CHK;
                end
            end
            H_CHK: begin
                nxt_st.dly = 1'b1;
                if (st_ff.dly) begin
                    // keep re-enabling until rww is free
                    if (st_ff.kind == K_RESUME &&
                        bus.csr_rdata[`FSPR_B_BUSY]) begin
                        nxt_st.st = H_POLL;
                    end else begin
                        nxt_st.st = H_IDLE;
                        nxt_st.mask = 1'b0;
                    end
                end
            end
            H_RDW: begin
                if (bus.lpm_valid) begin
                    nxt_st.lb = bus.lpm_data;
                    nxt_st.st = H_IDLE;
                    nxt_st.mask = 1'b0;
                end
            end
        endcase
        // register write once both halves are in
        if (st_ff.awg && st_ff.wg && !st_ff.bv) begin
            nxt_st.awg = 1'b0;
            nxt_st.wg = 1'b0;
            nxt_st.bv = 1'b1;
            nxt_st.br = `FSPR_RESP_OK;
            unique case (st_ff.awa)
                `FSPR_A_CTRL: begin
                    // orders while busy are dropped
                    if (st_ff.st == H_IDLE) begin
                        nxt_st.kind = fspr_kind_t'(st_ff.wd[9:8]);
                        nxt_st.cmd = st_ff.wd[7:0];
                        if (st_ff.wd[9:8] == K_RESUME) begin
                            nxt_st.cmd = {2'h0, `FSPR_CMD_REEN};
                        end
                        nxt_st.st = H_POLL;
                    end
                end
                `FSPR_A_ZPTR: nxt_st.z = merge(st_ff.z, st_ff.wd, st_ff.ws);
                `FSPR_A_DATA: nxt_st.r = merge(st_ff.r, st_ff.wd, st_ff.ws);
                `FSPR_A_STAT: nxt_st.br = `FSPR_RESP_OK;
                default: nxt_st.br = `FSPR_RESP_ERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awr;
    assign s_axi_wready = st_ff.wr;
    assign s_axi_bvalid = st_ff.bv;
    assign s_axi_bresp = st_ff.br;
    assign s_axi_arready = st_ff.arr;
    assign s_axi_rvalid = st_ff.rv;
    assign s_axi_rdata = st_ff.rd;
    assign s_axi_rresp = st_ff.rr;
    assign irq_mask = st_ff.mask;
    assign bus.csr_wr = st_ff.cw;
    assign bus.csr_wdata = st_ff.cmd;
    assign bus.spm = st_ff.spm;
    assign bus.lpm = st_ff.lpm;
    assign bus.z = st_ff.z;
    assign bus.r = st_ff.r;
    assign bus.ee_busy = st_ff.ee;
endmodule

// >>> hdl/fspr_if.sv
// link between the cpu core end and the flash control end
// no clock here; both ends run on the same aclk
`timescale 1ns/1ps
interface fspr_if;
    logic       csr_wr;
    logic [7:0] csr_wdata;
    logic [7:0] csr_rdata;
    logic       spm;
    logic       lpm;
    logic [15:0] z;
    logic [15:0] r;
    logic       ee_busy;
    logic [7:0] lpm_data;
    logic       lpm_valid;
    logic       rww_blocked;
    logic       cpu_halt;
    modport dev (
        input  csr_wr, csr_wdata, spm, lpm, z, r, ee_busy,
        output csr_rdata, lpm_data, lpm_valid, rww_blocked, cpu_halt
    );
    modport host (
        output csr_wr, csr_wdata, spm, lpm, z, r, ee_busy,
        input  csr_rdata, lpm_data, lpm_valid, rww_blocked, cpu_halt
    );
endinterface

// >>> hdl/fspr_pkg.sv
// types shared by both ends of the flash self-program link
// assumes fspr_defs.svh on the include path
package fspr_pkg;
`include "fspr_defs.svh"
    typedef logic [7:0]  fspr_byte_t;
    typedef logic [15:0] fspr_word_t;
    typedef logic [13:0] fspr_pc_t;
    typedef enum logic [1:0] {
        K_SPM    = 2'h0,
        K_LPM    = 2'h1,
        K_RESUME = 2'h2,
        K_CSR    = 2'h3
    } fspr_kind_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_POLL = 3'h1,
        H_EXEC = 3'h2,
        H_CHK  = 3'h3,
        H_RDW  = 3'h4
    } fspr_hst_t;
endpackage

// >>> tb/flash_self_program_readout_tb.sv
// testbench: host and flash ends joined by fspr_if, driven over axi
// assumes the hdl files compiled first; short op count for speed
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module flash_self_program_readout_tb;
    import fspr_pkg::*;
    localparam int unsigned OPC = 20;
    localparam logic [63:0] SIG = 64'h0123_4567_89ab_cdef; // arbitrary
    logic aclk = 0, aresetn = 0, por_n = 0, ee_busy_in = 0;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, rnd, seed;
    logic [1:0] bresp, rresp, resp;
    fspr_byte_t fuse_low, fuse_high, lock_bits, flash_rdata, lock_data, lc;
    logic [2:0] fuse_ext;
    logic buf_wr, page_erase, op_busy, buf_clear, page_write, lock_wr, irq_mask;
    logic [5:0] buf_word, wc;
    fspr_word_t buf_data, dc;
    logic [7:0] page_sel, pc, pg;
    fspr_pc_t boot_start;
    int mismatches = 0, checked = 0, cyc = 0, nclr = 0;
    fspr_if bus_if();
    fspr_dev #(.OP_CYCLES(OPC), .SIG_ROW(SIG)) fspr_dev_inst (.aclk,
        .aresetn, .por_n, .bus(bus_if.dev), .fuse_low, .fuse_high,
        .fuse_ext, .lock_bits, .flash_rdata, .buf_wr, .buf_word, .buf_data,
        .buf_clear, .page_erase, .page_write, .page_sel, .lock_wr,
        .lock_data, .op_busy, .boot_start);
    fspr_host fspr_host_inst (.aclk, .aresetn, .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .ee_busy_in, .irq_mask, .bus(bus_if.host));
    fspr_props #(.OP_CYCLES(OPC)) fspr_props_inst (.aclk, .aresetn,
        .csr_rdata(bus_if.csr_rdata), .lpm(bus_if.lpm), .z(bus_if.z),
        .lpm_data(bus_if.lpm_data), .lpm_valid(bus_if.lpm_valid),
        .rww_blocked(bus_if.rww_blocked), .cpu_halt(bus_if.cpu_halt));
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        if (buf_wr === 1'b1) begin
            wc <= buf_word;
            dc <= buf_data;
        end
        if ((page_erase | page_write) === 1'b1) pc <= page_sel;
        if (lock_wr === 1'b1) lc <= lock_data;
        if (buf_clear === 1'b1) nclr++;
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    function automatic fspr_pc_t boot_exp(input logic [1:0] s);
        case (s)
            2'h3: return 14'h3F00;
            2'h2: return 14'h3E00;
            2'h1: return 14'h3C00;
            default: return 14'h3800;
        endcase
    endfunction
    function automatic fspr_byte_t fuse_exp(input logic [1:0] s);
        case (s)
            2'h0: return fuse_low;
            2'h1: return lock_bits;
            2'h2: return {5'h1F, fuse_ext};
            default: return fuse_high;
        endcase
    endfunction
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awaddr <= a;
        wdata <= d;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp = bresp;
    endtask
    task axi_rd(input logic [3:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        rready <= 1'b1;
        araddr <= a;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
    endtask
    // run one sequence and wait for the sequencer to go idle
    task seq(input logic [1:0] k, input logic [7:0] c, input logic [15:0] zp);
        axi_wr(4'h4, {16'h0000, zp});
        axi_wr(4'h0, {22'h0, k, c});
        do axi_rd(4'hC); while (rd[16]);
    endtask
    task stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        seed = 32'h17c1;
        rnd = $random(seed);
        {fuse_ext, lock_bits, fuse_high, fuse_low} = rnd[26:0];
        rnd = $random(seed);
        flash_rdata = rnd[7:0];
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            fuse_high[2:1] <= i[1:0];
            repeat (2) @(posedge aclk);
            `CHK(boot_start, boot_exp(fuse_high[2:1]))
        end
        for (int i = 0; i < 4; i++) begin
            seq(2'h1, 8'h09, {1'b1, 13'h0, i[1:0]});
            `CHK(rd[15:8], fuse_exp(i[1:0]))
        end
        rnd = $random(seed);
        seq(2'h1, 8'h21, {13'h0, rnd[2:0]});
        `CHK(rd[15:8], SIG[8*rnd[2:0] +: 8])
        seq(2'h1, 8'h00, {13'h0, rnd[2:0]});
        `CHK(rd[15:8], flash_rdata)
        repeat (4) begin
            rnd = $random(seed);
            axi_wr(4'h8, {16'h0000, rnd[31:16]});
            seq(2'h0, 8'h01, {rnd[15:1], 1'b0});
            `CHK(wc, rnd[6:1])
            `CHK(dc, rnd[31:16])
        end
        // first erase lands in the no_read_while_write_region pages, second in the rww pages
        for (int i = 0; i < 2; i++) begin
            rnd = $random(seed);
            pg = (i == 0) ? {3'h7, rnd[4:0]} : {1'b0, rnd[6:0]};
            seq(2'h0, 8'h03, {1'b0, pg, 7'h00});
            `CHK(pc, pg)
            seq(2'h1, 8'h00, 16'h0000);
            `CHK(rd[15:8], (i == 1) ? 8'hFF : flash_rdata)
            seq(2'h2, 8'h00, 16'h0000);
            seq(2'h1, 8'h00, 16'h0000);
            `CHK(rd[15:8], flash_rdata)
        end
        // page write to rww page 1, word bits and byte select held at zero
        seq(2'h0, 8'h05, 16'h0080);
        `CHK(pc, 8'h01)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(op_busy, 1'b1)
        do axi_rd(4'hC); while (rd[0]);
        // two re-enables and the finished page write each clear the buffer
        `CHK(nclr, 3)
        ee_busy_in <= 1'b1;
        axi_wr(4'h0, {22'h0, 2'h0, 8'h01});
        repeat (8) @(posedge aclk);
        `CHK(bus_if.csr_rdata[0], 1'b0)
        `CHK(irq_mask, 1'b1)
        ee_busy_in <= 1'b0;
        do axi_rd(4'hC); while (rd[16]);
        // lock write by store, then two orders left without store or load
        axi_wr(4'h8, {16'h0000, rnd[15:0]});
        seq(2'h0, 8'h09, 16'h0001);
        `CHK(lc, rnd[7:0])
        seq(2'h3, 8'h21, 16'h0000);
        seq(2'h3, 8'h01, 16'h0000);
        repeat (6) @(posedge aclk);
        `CHK(bus_if.csr_rdata, 8'h00)
        axi_wr(4'h2, 32'h0000_0000);
        `CHK(resp, 2'h2)
        axi_rd(4'h6);
        `CHK(resp, 2'h2)
        stop_test();
    end
endmodule

// >>> tb/fspr_props.sv
// checker for the link between the cpu core end and the flash end
// assumes it watches the fspr_if signals on the shared aclk
`timescale 1ns/1ps
module fspr_props #(
    parameter int unsigned OP_CYCLES = 20
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // link signals
    input wire logic [7:0]  csr_rdata,
    input wire logic        lpm,
    input wire logic [15:0] z,
    input wire logic [7:0]  lpm_data,
    input wire logic        lpm_valid,
    input wire logic        rww_blocked,
    input wire logic        cpu_halt
);
    // not cleared by aresetn: a running op outlives that reset
    logic [31:0] cnt_ff = 32'h0000_0000;
    logic [31:0] nxt_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_comb nxt_cnt = csr_rdata[0] ? cnt_ff + 32'h0000_0001 : '0;
    always_ff @(posedge aclk) cnt_ff <= nxt_cnt;
    load_answer_a: assert property (lpm_valid == $past(lpm))
        else $error("load answer not one cycle after load");
    sig_clear_a: assert property ($rose(csr_rdata[5]) |-> ##[1:5]
        !csr_rdata[5]) else $error("signature mode did not clear");
    window_close_a: assert property ($rose(csr_rdata[0])
        && csr_rdata[3:1] == 3'h0 |-> ##[1:6] !csr_rdata[0])
        else $error("store enable outlived its window");
    rww_read_a: assert property (lpm && rww_blocked
        && !csr_rdata[0] && z[14:7] < 8'hE0 |=> lpm_data == 8'hFF)
        else $error("busy rww page readable");
    op_short_a: assert property ($fell(csr_rdata[0]) && cnt_ff > 8
        |-> cnt_ff >= OP_CYCLES) else $error("flash op too short");
    op_long_a: assert property (csr_rdata[0]
        |-> cnt_ff <= OP_CYCLES + 6) else $error("flash op too long");
    reenable_a: assert property ($rose(csr_rdata[4]) |-> ##[1:6]
        !rww_blocked) else $error("re-enable left rww busy");
    halt_op_a: assert property (cpu_halt |-> csr_rdata[0]
        || $past(csr_rdata[0])) else $error("halt without an op");
endmodule
